// ==== ecpt_pkg.sv ====
// Purpose: constants for the eight channel pulse width modulation timer
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: registers are one aligned word each
`default_nettype none
package ecpt_pkg;
  localparam int NCH = 8;
  localparam int NPAIR = 4;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_POLARITY = 8'h04;
  localparam logic [7:0] ADDR_CENTER = 8'h08;
  localparam logic [7:0] ADDR_JOIN = 8'h0c;
  localparam logic [7:0] ADDR_PERIOD_BASE = 8'h20;
  localparam logic [7:0] ADDR_DUTY_BASE = 8'h40;
  localparam logic [7:0] ADDR_COUNT_BASE = 8'h60;
  localparam logic [7:0] ADDR_OUT = 8'h80;
  localparam logic [7:0] BANK_MASK = 8'he0;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;
endpackage : ecpt_pkg
`default_nettype wire

// ==== ecpt_timer.sv ====
// Purpose: eight channel 8/16-bit pwm timer with wishbone register access
// Assumes: one clock, synchronous active-high reset
// Notes: period and duty writes take effect at once; no shadow registers
// Notes: a center-aligned period lasts twice the period value in clocks
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module ecpt_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [7:0] pwm_o
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] enable;
  logic [7:0] polarity;
  logic [7:0] center;
  logic [3:0] join_pair;
  logic [7:0] period [ecpt_pkg::NCH];
  logic [7:0] duty [ecpt_pkg::NCH];
  logic [7:0] count [ecpt_pkg::NCH];
  // unpacked so each pair's process owns only its own elements
  logic down [ecpt_pkg::NCH];
  logic wave [ecpt_pkg::NCH];
  logic req;
  logic wr;
  logic [2:0] idx;
  logic [7:0] bank;

  // ------------------------------------------------------------
  // bus decode and acknowledge
  // ------------------------------------------------------------
  // masking with ack stops a held request from being taken twice
  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i && sel_i[0];
  assign idx = adr_i[4:2];
  assign bank = adr_i & ecpt_pkg::BANK_MASK;

  // one wait state: ack in the cycle after the request is seen, then dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable <= 8'h00;
      polarity <= 8'h00;
      center <= 8'h00;
      join_pair <= 4'h0;
    end else if (wr) begin
      case (adr_i)
        ecpt_pkg::ADDR_ENABLE: enable <= dat_i[7:0];
        ecpt_pkg::ADDR_POLARITY: polarity <= dat_i[7:0];
        ecpt_pkg::ADDR_CENTER: center <= dat_i[7:0];
        ecpt_pkg::ADDR_JOIN: join_pair <= dat_i[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ecpt_pkg::NCH; i++) begin
        period[i] <= ecpt_pkg::PERIOD_RESET;
        duty[i] <= ecpt_pkg::DUTY_RESET;
      end
    end else if (wr && bank == ecpt_pkg::ADDR_PERIOD_BASE) begin
      period[idx] <= dat_i[7:0];
    end else if (wr && bank == ecpt_pkg::ADDR_DUTY_BASE) begin
      duty[idx] <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= ecpt_pkg::BUS_ERR_DATA;
    end else if (req) begin
      // holes read as zero and are still acknowledged, so software never stalls
      if (adr_i == ecpt_pkg::ADDR_ENABLE) dat_o <= {24'h000000, enable};
      else if (adr_i == ecpt_pkg::ADDR_POLARITY) dat_o <= {24'h000000, polarity};
      else if (adr_i == ecpt_pkg::ADDR_CENTER) dat_o <= {24'h000000, center};
      else if (adr_i == ecpt_pkg::ADDR_JOIN) dat_o <= {28'h0000000, join_pair};
      else if (adr_i == ecpt_pkg::ADDR_OUT) dat_o <= {24'h000000, pwm_o};
      else if (bank == ecpt_pkg::ADDR_PERIOD_BASE) dat_o <= {24'h000000, period[idx]};
      else if (bank == ecpt_pkg::ADDR_DUTY_BASE) dat_o <= {24'h000000, duty[idx]};
      else if (bank == ecpt_pkg::ADDR_COUNT_BASE) dat_o <= {24'h000000, count[idx]};
      else dat_o <= ecpt_pkg::BUS_ERR_DATA;
    end
  end

  // ------------------------------------------------------------
  // counters and comparators, one generate step per pair
  // ------------------------------------------------------------
  for (genvar p = 0; p < ecpt_pkg::NPAIR; p++) begin : g_pair
    localparam int LO = 2 * p;
    localparam int HI = 2 * p + 1;
    logic [15:0] cnt16;
    logic [15:0] per16;
    logic [15:0] dut16;
    logic [15:0] next_cnt16;
    logic next_down16;
    logic act16;
    logic [7:0] next_lo;
    logic next_dlo;
    logic act_lo;
    logic [7:0] next_hi;
    logic next_dhi;
    logic act_hi;
    logic joined;

    assign joined = join_pair[p];
    assign cnt16 = {count[HI], count[LO]};
    assign per16 = {period[HI], period[LO]};
    assign dut16 = {duty[HI], duty[LO]};

    // left mode wraps at period-1; center mode counts 0 up to period and back down to 0
    // center turns at zero going down, so zero is seen once a period and duty 1 still pulses
    always_comb begin
      next_down16 = down[HI];
      next_cnt16 = cnt16 + 16'h0001;
      if (center[HI]) begin
        if (!down[HI] && cnt16 >= per16) next_down16 = 1'b1;
        else if (down[HI] && cnt16 == 16'h0000) next_down16 = 1'b0;
        if (next_down16 && cnt16 != 16'h0000) next_cnt16 = cnt16 - 16'h0001;
        else if (!next_down16 && cnt16 < per16) next_cnt16 = cnt16 + 16'h0001;
        else next_cnt16 = 16'h0000;
      end else if (cnt16 + 16'h0001 >= per16) begin
        next_cnt16 = 16'h0000;
        next_down16 = 1'b0;
      end
      // duty 0 never active, duty >= period always active, so no glitch at either end
      act16 = (dut16 != 16'h0000) && (cnt16 < dut16 || dut16 >= per16);
    end

    always_comb begin
      next_dlo = down[LO];
      next_lo = count[LO] + 8'h01;
      if (center[LO]) begin
        if (!down[LO] && count[LO] >= period[LO]) next_dlo = 1'b1;
        else if (down[LO] && count[LO] == 8'h00) next_dlo = 1'b0;
        if (next_dlo && count[LO] != 8'h00) next_lo = count[LO] - 8'h01;
        else if (!next_dlo && count[LO] < period[LO]) next_lo = count[LO] + 8'h01;
        else next_lo = 8'h00;
      end else if (count[LO] + 8'h01 >= period[LO]) begin
        next_lo = 8'h00;
        next_dlo = 1'b0;
      end
      act_lo = (duty[LO] != 8'h00) && (count[LO] < duty[LO] || duty[LO] >= period[LO]);
    end

    always_comb begin
      next_dhi = down[HI];
      next_hi = count[HI] + 8'h01;
      if (center[HI]) begin
        if (!down[HI] && count[HI] >= period[HI]) next_dhi = 1'b1;
        else if (down[HI] && count[HI] == 8'h00) next_dhi = 1'b0;
        if (next_dhi && count[HI] != 8'h00) next_hi = count[HI] - 8'h01;
        else if (!next_dhi && count[HI] < period[HI]) next_hi = count[HI] + 8'h01;
        else next_hi = 8'h00;
      end else if (count[HI] + 8'h01 >= period[HI]) begin
        next_hi = 8'h00;
        next_dhi = 1'b0;
      end
      act_hi = (duty[HI] != 8'h00) && (count[HI] < duty[HI] || duty[HI] >= period[HI]);
    end

    // disabled channels hold their counter at zero, a joined pair by its high channel's enable only, so enabling starts a clean period
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        count[LO] <= 8'h00;
        count[HI] <= 8'h00;
        down[LO] <= 1'b0;
        down[HI] <= 1'b0;
        wave[LO] <= 1'b0;
        wave[HI] <= 1'b0;
      end else if (joined) begin
        if (enable[HI]) begin
          {count[HI], count[LO]} <= next_cnt16;
          down[HI] <= next_down16;
        end else begin
          {count[HI], count[LO]} <= 16'h0000;
          down[HI] <= 1'b0;
        end
        // the low half keeps no direction or wave of its own while joined
        down[LO] <= 1'b0;
        wave[HI] <= enable[HI] && act16;
        wave[LO] <= 1'b0;
      end else begin
        count[LO] <= enable[LO] ? next_lo : 8'h00;
        down[LO] <= enable[LO] && next_dlo;
        count[HI] <= enable[HI] ? next_hi : 8'h00;
        down[HI] <= enable[HI] && next_dhi;
        wave[LO] <= enable[LO] && act_lo;
        wave[HI] <= enable[HI] && act_hi;
      end
    end
  end

  // ------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------
  // polarity set: duty portion high; clear: duty portion low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_o <= 8'h00;
    end else begin
      for (int i = 0; i < ecpt_pkg::NCH; i++) begin
        pwm_o[i] <= ~(wave[i] ^ polarity[i]);
      end
    end
  end
endmodule : ecpt_timer
`default_nettype wire

// ==== ecpt_asserts.sv ====
// Purpose: bus and output checks for ecpt_timer
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the top ports; 8'h10 is an unmapped address
`timescale 1ns/1ps
`default_nettype none
module ecpt_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [7:0] pwm_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence
  chk_ack_next: assert property (s_req |=> s_ack_pulse) else $error("ack late");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_idle_ack: assert property (!cyc_i |=> !ack_o) else $error("ack while idle");
  chk_upper_zero: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  // read data must not drift between requests, software may sample it late
  chk_dat_hold: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
    else $error("read data moved");
  chk_unmapped: assert property (ack_o && !we_i && adr_i == 8'h10 |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_out_read: assert property (ack_o && !we_i && adr_i == ecpt_pkg::ADDR_OUT
    |-> dat_o[7:0] == $past(pwm_o)) else $error("output readback");
  chk_reset_idle: assert property ($fell(rst_i) |=> pwm_o == 8'hff)
    else $error("idle level after reset");
endmodule : ecpt_asserts
bind ecpt_timer ecpt_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .pwm_o(pwm_o));
`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench for ecpt_timer
// Assumes: one-cycle ack, one idle cycle between requests
// Notes: wave checks count high cycles over whole periods
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack_o;
  logic [7:0] adr = 8'h00, pwm_o;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0, dat_o, v;
  logic [31:0] exp_q[$];
  int n_fail = 0, n_checks = 0, seed = 32'h818c;
  always #20 clk_i = ~clk_i;
  ecpt_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .pwm_o(pwm_o));
  task automatic print_verdict();
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t saw %h wanted %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    i = 0;
    do begin @(posedge clk_i); i++; end while (ack_o !== 1'b1 && i < 20);
    if (i == 20) begin n_fail++; print_verdict(); end
    cyc <= 1'b0; stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // settle first: period and duty apply at once, so a part period may straddle
  task automatic hi(input int ch, input int n, input int e);
    int c;
    c = 0;
    repeat (300) @(posedge clk_i);
    repeat (n) begin
      @(posedge clk_i);
      if (pwm_o[ch] === 1'b1) c++;
      else if (pwm_o[ch] !== 1'b0) c += 1000;
    end
    check(32'(c), 32'(e));
  endtask : hi
  always @(posedge clk_i) if (ack_o === 1'b1 && we === 1'b0) check(dat_o, exp_q.pop_front());
  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ecpt_pkg::ADDR_OUT, 32'hff);
    rd(ecpt_pkg::ADDR_PERIOD_BASE, 32'hff);
    rd(ecpt_pkg::ADDR_ENABLE, 32'h0);
    rd(8'h10, 32'h0);
    for (int n = 0; n < 8; n++) begin
      v = $random(seed);
      wr(ecpt_pkg::ADDR_DUTY_BASE + 8'(4 * n), v);
      rd(ecpt_pkg::ADDR_DUTY_BASE + 8'(4 * n), {24'h0, v[7:0]});
    end
    sel <= 4'h0;
    wr(ecpt_pkg::ADDR_ENABLE, 32'hff);
    sel <= 4'hf;
    rd(ecpt_pkg::ADDR_ENABLE, 32'h0);
    rd(ecpt_pkg::ADDR_COUNT_BASE + 8'h1c, 32'h0);
    wr(ecpt_pkg::ADDR_PERIOD_BASE, 32'h4);
    wr(ecpt_pkg::ADDR_DUTY_BASE, 32'h1);
    wr(ecpt_pkg::ADDR_POLARITY, 32'h1);
    wr(ecpt_pkg::ADDR_ENABLE, 32'h1);
    hi(0, 8, 2);
    wr(ecpt_pkg::ADDR_DUTY_BASE, 32'h0);
    hi(0, 8, 0);
    wr(ecpt_pkg::ADDR_DUTY_BASE, 32'h4);
    hi(0, 8, 8);
    wr(ecpt_pkg::ADDR_DUTY_BASE, 32'h1);
    wr(ecpt_pkg::ADDR_POLARITY, 32'h0);
    hi(0, 8, 6);
    wr(ecpt_pkg::ADDR_POLARITY, 32'h1);
    wr(ecpt_pkg::ADDR_CENTER, 32'h1);
    hi(0, 16, 2);
    wr(ecpt_pkg::ADDR_CENTER, 32'h0);
    wr(ecpt_pkg::ADDR_PERIOD_BASE + 8'h4, 32'h1);
    wr(ecpt_pkg::ADDR_DUTY_BASE, 32'h0);
    wr(ecpt_pkg::ADDR_DUTY_BASE + 8'h4, 32'h1);
    wr(ecpt_pkg::ADDR_POLARITY, 32'h2);
    wr(ecpt_pkg::ADDR_JOIN, 32'h1);
    wr(ecpt_pkg::ADDR_ENABLE, 32'h2);
    hi(1, 260, 256);
    hi(0, 8, 8);
    hi(7, 8, 8);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
